// file: rtl/adcp_cal.sv
// Calibration sequencer on the sample clock: power-up delay, command qualify, run.
// Assumes i_cal_pin and i_pd are already synchronised to i_clk.
module adcp_cal #(
   parameter int CAL_LOW_MIN = 80,
   parameter int CAL_HIGH_MIN = 80,
   parameter int CAL_RUN_CYCLES = 1024,
   parameter int DELAY_SHORT = 64,
   parameter int DELAY_LONG = 4000
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_cal_pin,
   input wire logic i_delay_long,
   input wire logic i_pd,
   output logic o_active
);
   localparam int CW = adcp_pkg::ADCP_CNT_W;

   initial begin
      if (CAL_LOW_MIN < 1 || CAL_HIGH_MIN < 1 || CAL_RUN_CYCLES < 1 || DELAY_SHORT < 1 ||
          DELAY_LONG < 1 || DELAY_LONG >= 2 ** CW || CAL_RUN_CYCLES >= 2 ** CW ||
          CAL_LOW_MIN >= 2 ** CW || CAL_HIGH_MIN >= 2 ** CW || DELAY_SHORT >= 2 ** CW)
         $error("adcp_cal: count out of range");
   end

   adcp_pkg::adcp_cal_state_type state_reg, state_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   wire [CW-1:0] cnt_inc = cnt_reg + CW'(1);
   wire [CW-1:0] delay_len = i_delay_long ? CW'(DELAY_LONG) : CW'(DELAY_SHORT);

   // Next state: low count qualifies, high count starts a run
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         adcp_pkg::ADCP_CAL_DELAY: begin
            cnt_next = cnt_inc;
            if (cnt_inc >= delay_len) begin
               state_next = adcp_pkg::ADCP_CAL_RUN;
               cnt_next = '0;
            end
         end
         adcp_pkg::ADCP_CAL_RUN: begin
            cnt_next = cnt_inc;
            if (cnt_inc >= CW'(CAL_RUN_CYCLES)) begin
               state_next = adcp_pkg::ADCP_CAL_IDLE;
               cnt_next = '0;
            end
         end
         adcp_pkg::ADCP_CAL_IDLE: begin
            if (!i_cal_pin) begin
               if (cnt_reg < CW'(CAL_LOW_MIN))
                  cnt_next = cnt_inc;
            end else if (cnt_reg >= CW'(CAL_LOW_MIN)) begin
               state_next = adcp_pkg::ADCP_CAL_HIGH;
               cnt_next = CW'(1);
            end else begin
               cnt_next = '0;
            end
         end
         adcp_pkg::ADCP_CAL_HIGH: begin
            // A full high count already seen starts the run even if the pin drops now
            if (cnt_reg >= CW'(CAL_HIGH_MIN)) begin
               state_next = adcp_pkg::ADCP_CAL_RUN;
               cnt_next = '0;
            end else if (!i_cal_pin) begin
               state_next = adcp_pkg::ADCP_CAL_IDLE;
               cnt_next = CW'(1);
            end else begin
               cnt_next = cnt_inc;
            end
         end
      endcase
   end

   // Power down restarts the power-up delay
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= adcp_pkg::ADCP_CAL_DELAY;
         cnt_reg <= '0;
      end else if (i_pd) begin
         state_reg <= adcp_pkg::ADCP_CAL_DELAY;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign o_active = (state_reg == adcp_pkg::ADCP_CAL_RUN);
endmodule

// file: rtl/adcp_pkg.sv
// Constants and types for the converter control-pin and output-mode block.
// Assumes a classic Wishbone bus with 32-bit data on i_clk, and a sample clock from the converter core.
// Function
// - Range pin floating or mid-supply enables extended control mode.
// - Outside extended mode, range pin low selects reduced range, high selects higher.
// - Normal mode, swing pin high gives normal output swing.
// - Normal mode, swing pin grounded gives reduced swing and lower power.
// - Extended mode, swing pin is the serial clock driven by the controller.
// - Normal mode, edge pin level picks the output clock edge for data changes.
// - Edge pin floating or mid-supply selects double data rate output clocking.
// - Extended mode, edge pin is serial data driven alongside the serial clock.
// - Positive pulse on output clock sync reset restarts the output data clock.
// - Power-down input high keeps the whole device powered down.
// - Calibration pin starts a run only after minimum low count then minimum high count; a run also follows the power-up delay.
// - Results are split one-to-two onto two buses at half the sample rate.
// - Each result leaves as an 8-bit offset binary word.
// - Calibration active output stays high while calibration runs.
// - Range pin floating makes delay pin the serial select and forces the short calibration delay.
// - The analog input is sampled on the falling edge of the sample clock.
package adcp_pkg;
   // Register byte offsets
   localparam logic [7:0] ADCP_CTRL_OFS = 8'h00;
   localparam logic [7:0] ADCP_STAT_OFS = 8'h04;
   localparam logic [7:0] ADCP_SER_OFS = 8'h08;
   // Control register fields
   localparam int ADCP_CTRL_RANGE_BIT = 0;
   localparam int ADCP_CTRL_SWING_BIT = 1;
   localparam int ADCP_CTRL_EDGE_BIT = 2;
   localparam int ADCP_CTRL_DDR_BIT = 3;
   localparam int ADCP_CTRL_W = 4;
   localparam logic [3:0] ADCP_CTRL_RESET = 4'hA;
   // Serial capture width and offset binary sign flip
   localparam int ADCP_SER_W = 16;
   localparam int ADCP_DATA_W = 8;
   localparam logic [7:0] ADCP_SIGN_FLIP = 8'h80;
   // Calibration counter width
   localparam int ADCP_CNT_W = 16;

   typedef enum logic [1:0] {
      ADCP_LVL_LOW = 2'h0,
      ADCP_LVL_HIGH = 2'h1,
      ADCP_LVL_MID = 2'h2
   } adcp_level_type;

   // Window comparator outputs of a three-level pin
   typedef struct packed {
      logic above_high;
      logic below_low;
   } adcp_tri_type;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } adcp_wb_req_type;

   typedef enum logic [1:0] {
      ADCP_CAL_DELAY = 2'h0,
      ADCP_CAL_RUN = 2'h1,
      ADCP_CAL_IDLE = 2'h3,
      ADCP_CAL_HIGH = 2'h2
   } adcp_cal_state_type;
endpackage

// file: rtl/adcp_sync.sv
// Two flip-flop synchroniser for slow levels.
// Assumes each bit changes independently and stays put for several destination clocks.
module adcp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;

   // First stage feeds only the second
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_reg <= '0;
         o_sync <= '0;
      end else begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end
endmodule

// file: rtl/adcp_top.sv
// Control-pin decode, output mode, serial capture and 1:2 output demultiplexer.
// Assumes Wishbone on i_clk, sample clock i_smp_clk unrelated to it, pins asynchronous to both,
// and i_conv_code from the quantizer, valid around the falling sample clock edge.
//
// The implementer's own choices: the address map and register access over Wishbone.
module adcp_top #(
   parameter int CAL_LOW_MIN = 80,
   parameter int CAL_HIGH_MIN = 80,
   parameter int CAL_RUN_CYCLES = 1024,
   parameter int DELAY_SHORT = 64,
   parameter int DELAY_LONG = 4000
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire adcp_pkg::adcp_wb_req_type i_wb_req,
   output logic o_wb_ack,
   output logic [31:0] o_wb_dat,
   input wire adcp_pkg::adcp_tri_type i_input_range_select,
   input wire adcp_pkg::adcp_tri_type i_output_edge_select,
   input wire logic i_output_swing_select,
   input wire logic i_calibration_start_delay,
   input wire logic i_power_down_input,
   input wire logic i_calibrate,
   input wire logic i_output_clock_sync_reset,
   input wire logic i_smp_clk,
   input wire logic [7:0] i_conv_code,
   output logic o_extended_control_enable,
   output logic o_range_high,
   output logic o_swing_normal,
   output logic o_power_down,
   output logic o_calibration_active_flag,
   output logic o_output_data_clock,
   output logic [7:0] o_direct_bus,
   output logic [7:0] o_delayed_bus
);
   localparam int DW = adcp_pkg::ADCP_DATA_W;
   localparam int SW = adcp_pkg::ADCP_SER_W;
   localparam int CTW = adcp_pkg::ADCP_CTRL_W;

   initial begin
      if (DW != 8)
         $error("adcp_top: data width must be 8");
   end

   // Three-level decode from window comparator outputs
   function automatic adcp_pkg::adcp_level_type tri_decode(input adcp_pkg::adcp_tri_type p);
      if (p.above_high && !p.below_low)
         return adcp_pkg::ADCP_LVL_HIGH;
      else if (p.below_low && !p.above_high)
         return adcp_pkg::ADCP_LVL_LOW;
      else
         return adcp_pkg::ADCP_LVL_MID;
   endfunction

   // ---------------- Bus clock domain ----------------
   logic [1:0] range_s, edge_s;
   logic swing_s, dly_s, pd_s, cal_act_s, cal_act_l;
   logic [1:0] prime_reg;

   // Pins enter through two flip-flops
   adcp_sync #(.WIDTH(8)) u_pin_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async({i_input_range_select, i_output_edge_select, i_output_swing_select,
                i_calibration_start_delay, i_power_down_input, cal_act_l}),
      .o_sync({range_s, edge_s, swing_s, dly_s, pd_s, cal_act_s})
   );

   // Synchroniser reset reads as mid level, so mode decode waits until real pin levels arrive
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst)
         prime_reg <= 2'h0;
      else
         prime_reg <= {prime_reg[0], 1'b1};
   end

   // Pin decode and mode selection
   wire adcp_pkg::adcp_level_type range_lvl = tri_decode(range_s);
   wire adcp_pkg::adcp_level_type edge_lvl = tri_decode(edge_s);
   wire ext_mode = prime_reg[1] && (range_lvl == adcp_pkg::ADCP_LVL_MID);

   logic [CTW-1:0] ctrl_reg;
   logic [SW-1:0] ser_shift_reg;
   logic [5:0] ser_cnt_reg;
   logic sclk_prev_reg;

   // Effective settings: registers in extended mode (long delay forced off), pins otherwise
   wire range_eff = ext_mode ? ctrl_reg[adcp_pkg::ADCP_CTRL_RANGE_BIT]
                             : (range_lvl == adcp_pkg::ADCP_LVL_HIGH);
   wire swing_eff = ext_mode ? ctrl_reg[adcp_pkg::ADCP_CTRL_SWING_BIT] : swing_s;
   wire edge_eff = ext_mode ? ctrl_reg[adcp_pkg::ADCP_CTRL_EDGE_BIT]
                            : (edge_lvl == adcp_pkg::ADCP_LVL_HIGH);
   wire ddr_eff = ext_mode ? ctrl_reg[adcp_pkg::ADCP_CTRL_DDR_BIT]
                           : (edge_lvl == adcp_pkg::ADCP_LVL_MID);
   wire dly_long_eff = ext_mode ? 1'b0 : dly_s;

   // Serial interface roles in extended mode, select is active low
   wire ser_sel = ext_mode && !dly_s;
   wire ser_clk = swing_s;
   wire ser_dat = (edge_lvl == adcp_pkg::ADCP_LVL_HIGH);
   wire ser_rise = ser_clk && !sclk_prev_reg;

   // Serial shift capture on serial clock rising edges while selected
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sclk_prev_reg <= 1'b0;
         ser_shift_reg <= '0;
         ser_cnt_reg <= '0;
      end else begin
         sclk_prev_reg <= ser_clk;
         if (!ser_sel) begin
            ser_cnt_reg <= '0;
         end else if (ser_rise) begin
            ser_shift_reg <= {ser_shift_reg[SW-2:0], ser_dat};
            if (ser_cnt_reg != 6'h3F)
               ser_cnt_reg <= ser_cnt_reg + 6'h01;
         end
      end
   end

   // Mode outputs from flip-flops
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_extended_control_enable <= 1'b0;
         o_range_high <= 1'b0;
         o_swing_normal <= 1'b0;
         o_power_down <= 1'b1;
      end else begin
         o_extended_control_enable <= ext_mode;
         o_range_high <= range_eff;
         o_swing_normal <= swing_eff && !pd_s;
         o_power_down <= pd_s;
      end
   end

   // Wishbone decode
   wire wb_req = i_wb_req.cyc && i_wb_req.stb && !o_wb_ack;
   wire hit_ctrl = (i_wb_req.adr == adcp_pkg::ADCP_CTRL_OFS);
   wire hit_stat = (i_wb_req.adr == adcp_pkg::ADCP_STAT_OFS);
   wire hit_ser = (i_wb_req.adr == adcp_pkg::ADCP_SER_OFS);
   wire ctrl_wr = wb_req && i_wb_req.we && hit_ctrl && i_wb_req.sel[0];
   wire [31:0] stat_word = {20'h00000, ser_cnt_reg, dly_long_eff, ddr_eff, edge_eff,
                            cal_act_s, pd_s, ext_mode};
   wire [31:0] rd_word = hit_ctrl ? {28'h0000000, ctrl_reg} :
                         hit_stat ? stat_word :
                         hit_ser ? {16'h0000, ser_shift_reg} : 32'h00000000;

   // One-cycle answer; unmapped reads return zero, writes are dropped
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= '0;
         ctrl_reg <= adcp_pkg::ADCP_CTRL_RESET;
      end else begin
         o_wb_ack <= wb_req;
         if (wb_req && !i_wb_req.we)
            o_wb_dat <= rd_word;
         if (ctrl_wr)
            ctrl_reg <= i_wb_req.dat[CTW-1:0];
      end
   end

   // ---------------- Sample clock domain ----------------
   logic ddr_l, edge_l, dly_l, pd_l, cal_pin_l, crst_l;

   // Settings and pins cross as quasi-static levels
   adcp_sync #(.WIDTH(6)) u_link_sync (
      .i_clk(i_smp_clk),
      .i_rst(i_rst),
      .i_async({ddr_eff, edge_eff, dly_long_eff, i_power_down_input, i_calibrate,
                i_output_clock_sync_reset}),
      .o_sync({ddr_l, edge_l, dly_l, pd_l, cal_pin_l, crst_l})
   );

   adcp_cal #(
      .CAL_LOW_MIN(CAL_LOW_MIN),
      .CAL_HIGH_MIN(CAL_HIGH_MIN),
      .CAL_RUN_CYCLES(CAL_RUN_CYCLES),
      .DELAY_SHORT(DELAY_SHORT),
      .DELAY_LONG(DELAY_LONG)
   ) u_cal (
      .i_clk(i_smp_clk),
      .i_rst(i_rst),
      .i_cal_pin(cal_pin_l),
      .i_delay_long(dly_l),
      .i_pd(pd_l),
      .o_active(cal_act_l)
   );

   logic [DW-1:0] smp_reg, held_reg;
   logic phase_reg, crst_prev_reg;

   // Quantizer code taken on the falling sample clock edge, flipped to offset binary
   always_ff @(negedge i_smp_clk or posedge i_rst) begin
      if (i_rst)
         smp_reg <= '0;
      else
         smp_reg <= i_conv_code ^ adcp_pkg::ADCP_SIGN_FLIP;
   end

   wire crst_pulse = crst_l && !crst_prev_reg;
   wire halt = pd_l || crst_pulse;

   // Demultiplexer and output data clock
   always_ff @(posedge i_smp_clk or posedge i_rst) begin
      if (i_rst) begin
         crst_prev_reg <= 1'b0;
         phase_reg <= 1'b0;
         held_reg <= '0;
         o_direct_bus <= '0;
         o_delayed_bus <= '0;
         o_output_data_clock <= 1'b0;
         o_calibration_active_flag <= 1'b0;
      end else begin
         crst_prev_reg <= crst_l;
         o_calibration_active_flag <= cal_act_l && !pd_l;
         if (halt) begin
            phase_reg <= 1'b0;
            o_output_data_clock <= 1'b0;
            if (pd_l) begin
               o_direct_bus <= '0;
               o_delayed_bus <= '0;
            end
         end else begin
            phase_reg <= !phase_reg;
            if (!phase_reg) begin
               held_reg <= smp_reg;
            end else begin
               o_delayed_bus <= held_reg;
               o_direct_bus <= smp_reg;
            end
            if (ddr_l) begin
               if (phase_reg)
                  o_output_data_clock <= !o_output_data_clock;
            end else begin
               o_output_data_clock <= phase_reg ? edge_l : !edge_l;
            end
         end
      end
   end
endmodule

// file: test/adcp_chk.sv
// Concurrent checks on the control-pin block, bound to its top module.
// Assumes pins stay steady long enough to cross the two-stage synchronisers.
module adcp_chk #(
   parameter int CAL_RUN_CYCLES = 1024
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire adcp_pkg::adcp_tri_type i_input_range_select,
   input wire logic i_output_swing_select,
   input wire logic i_power_down_input,
   input wire logic i_smp_clk,
   input wire logic o_extended_control_enable,
   input wire logic o_range_high,
   input wire logic o_swing_normal,
   input wire logic o_power_down,
   input wire logic o_calibration_active_flag,
   input wire logic [7:0] o_direct_bus
);
   timeunit 1ns;
   timeprecision 1ps;
   // Range pin level decode
   wire rng_mid = (i_input_range_select == 2'h0) || (i_input_range_select == 2'h3);
   wire rng_hi = i_input_range_select == 2'h2;
   wire rng_lo = i_input_range_select == 2'h1;
   wire norm_on = rng_hi && !i_power_down_input;

   a_ext_mid_enter: assert property (@(posedge i_clk) disable iff (i_rst)
      rng_mid [*4] |=> o_extended_control_enable) else $error("ext mode not entered");
   a_range_high_sel: assert property (@(posedge i_clk) disable iff (i_rst)
      rng_hi [*4] |=> !o_extended_control_enable && o_range_high) else $error("high range wrong");
   a_range_low_sel: assert property (@(posedge i_clk) disable iff (i_rst)
      rng_lo [*4] |=> !o_extended_control_enable && !o_range_high) else $error("low range wrong");
   a_swing_normal_hi: assert property (@(posedge i_clk) disable iff (i_rst)
      (norm_on && i_output_swing_select) [*4] |=> o_swing_normal) else $error("swing not normal");
   a_swing_reduced_lo: assert property (@(posedge i_clk) disable iff (i_rst)
      (rng_hi && !i_output_swing_select) [*4] |=> !o_swing_normal) else $error("swing not reduced");
   a_pd_follows_pin: assert property (@(posedge i_clk) disable iff (i_rst)
      i_power_down_input [*4] |=> o_power_down) else $error("power down missed");
   a_pd_bus_zero: assert property (@(posedge i_smp_clk) disable iff (i_rst)
      i_power_down_input [*8] |=> o_direct_bus == 8'h00) else $error("bus active in power down");
   a_cal_run_holds: assert property (@(posedge i_smp_clk) disable iff (i_rst)
      $rose(o_calibration_active_flag) |=> o_calibration_active_flag [*8]) else $error("cal flag short");

   int cal_len = 0;
   // Length of the current calibration-active stretch
   always_ff @(posedge i_smp_clk) begin
      cal_len <= o_calibration_active_flag ? cal_len + 1 : 0;
   end

   a_cal_run_len: assert property (@(posedge i_smp_clk) disable iff (i_rst)
      $fell(o_calibration_active_flag) && !i_power_down_input |-> cal_len == CAL_RUN_CYCLES)
      else $error("cal run length wrong");

   // Main scenarios reached
   c_cal: cover property (@(posedge i_smp_clk) $rose(o_calibration_active_flag));
   c_ext: cover property (@(posedge i_clk) $rose(o_extended_control_enable));
   c_pd: cover property (@(posedge i_clk) $rose(o_power_down));
endmodule

bind adcp_top adcp_chk #(.CAL_RUN_CYCLES(CAL_RUN_CYCLES)) chk_u (.i_clk(i_clk), .i_rst(i_rst),
   .i_input_range_select(i_input_range_select), .i_output_swing_select(i_output_swing_select),
   .i_power_down_input(i_power_down_input), .i_smp_clk(i_smp_clk),
   .o_extended_control_enable(o_extended_control_enable), .o_range_high(o_range_high),
   .o_swing_normal(o_swing_normal), .o_power_down(o_power_down),
   .o_calibration_active_flag(o_calibration_active_flag), .o_direct_bus(o_direct_bus));

// file: test/adcp_rx_model.sv
// Capture model of the receiving logic behind the two output buses.
// Assumes buses and output clock are launched from the rising sample clock.
module adcp_rx_model (
   input wire logic i_smp_clk,
   input wire logic i_data_clk,
   input wire logic [7:0] i_direct_bus,
   input wire logic [7:0] i_delayed_bus,
   output logic [7:0] o_direct_word,
   output logic [7:0] o_delayed_word,
   output int o_rise_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_prev = 1'b0;
   int rise_cnt = 0;
   // Latch the pair on each rising output clock and count the rises
   always @(posedge i_smp_clk) begin
      clk_prev <= i_data_clk;
      if (i_data_clk && !clk_prev) begin
         o_direct_word <= i_direct_bus;
         o_delayed_word <= i_delayed_bus;
         rise_cnt <= rise_cnt + 1;
      end
   end
   assign o_rise_count = rise_cnt;
endmodule

// file: test/tb_adc_control_pin_decoder.sv
// Self-checking bench for the control-pin decoder with a capture model on the buses.
// Assumes the shortened calibration counts and a 12 ns sample clock.
module tb_adc_control_pin_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_smp_clk = 1'b0;
   adcp_pkg::adcp_wb_req_type req = '0;
   adcp_pkg::adcp_tri_type rng = 2'h2;
   adcp_pkg::adcp_tri_type edg = 2'h2;
   logic swing = 1'b1, dly = 1'b0, pd = 1'b0, cal = 1'b0, srst = 1'b0;
   logic [7:0] code = 8'h00;
   logic ack, ext, rng_hi, swing_n, pd_o, cal_f, output_data_clock;
   logic [31:0] rdat, q;
   logic [7:0] dir_b, del_b, dir_w, del_w;
   int rises;
   int err_total = 0;
   int comparisons = 0;

   // Bus clock and unrelated sample clock
   initial forever #20 i_clk = ~i_clk;
   initial begin
      #3;
      forever #6 i_smp_clk = ~i_smp_clk;
   end

   adcp_top #(.CAL_LOW_MIN(4), .CAL_HIGH_MIN(4), .CAL_RUN_CYCLES(16), .DELAY_SHORT(4), .DELAY_LONG(20)) dut_u (
      .i_clk(i_clk), .i_rst(i_rst), .i_wb_req(req), .o_wb_ack(ack), .o_wb_dat(rdat),
      .i_input_range_select(rng), .i_output_edge_select(edg), .i_output_swing_select(swing),
      .i_calibration_start_delay(dly), .i_power_down_input(pd), .i_calibrate(cal),
      .i_output_clock_sync_reset(srst), .i_smp_clk(i_smp_clk), .i_conv_code(code),
      .o_extended_control_enable(ext), .o_range_high(rng_hi), .o_swing_normal(swing_n),
      .o_power_down(pd_o), .o_calibration_active_flag(cal_f), .o_output_data_clock(output_data_clock),
      .o_direct_bus(dir_b), .o_delayed_bus(del_b));

   adcp_rx_model rx_u (.i_smp_clk(i_smp_clk), .i_data_clk(output_data_clock), .i_direct_bus(dir_b),
      .i_delayed_bus(del_b), .o_direct_word(dir_w), .o_delayed_word(del_w), .o_rise_count(rises));

   task automatic finish_test(input bit hang);
      if (hang) err_total++;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s got %h", $time, msg, got);
      end
   endtask

   // Classic single Wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge i_clk);
      req <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
      do begin
         @(posedge i_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) finish_test(1'b1);
      q = rdat;
      req <= '0;
   endtask

   task automatic pins(input logic [1:0] r, input logic [1:0] e, input logic s);
      @(posedge i_clk);
      rng <= r;
      edg <= e;
      swing <= s;
      repeat (6) @(posedge i_clk);
   endtask

   task automatic t_normal;
      wb(1'b0, 8'h40, 32'h0);
      check(q, 32'h0, "unmapped read");
      pins(2'h2, 2'h2, 1'b1);
      check(ext, 1'b0, "ext in normal");
      check(rng_hi, 1'b1, "range high");
      check(swing_n, 1'b1, "swing normal");
      pins(2'h1, 2'h2, 1'b0);
      check(rng_hi, 1'b0, "range low");
      check(swing_n, 1'b0, "swing reduced");
      $display("done normal");
   endtask

   task automatic t_edge;
      logic [1:0] pin [3] = '{2'h2, 2'h1, 2'h0};
      logic [31:0] msk [3] = '{32'h18, 32'h18, 32'h10};
      logic [31:0] exp [3] = '{32'h08, 32'h00, 32'h10};
      int r0, d;
      for (int i = 0; i < 3; i++) begin
         pins(2'h2, pin[i], 1'b1);
         wb(1'b0, 8'h04, 32'h0);
         check(q & msk[i], exp[i], "edge decode");
         r0 = rises;
         repeat (40) @(posedge i_smp_clk);
         d = rises - r0 - (i < 2 ? 20 : 10);
         check(d >= -1 && d <= 1, 1'b1, "output clock rate");
      end
      $display("done edge");
   endtask

   task automatic t_data;
      logic [7:0] v [2] = '{8'h05, 8'hFB};
      pins(2'h2, 2'h2, 1'b1);
      repeat (20) @(posedge i_smp_clk) code <= code + 8'h01;
      check(8'(dir_w - del_w), 8'h01, "pair order");
      for (int i = 0; i < 2; i++) begin
         @(posedge i_smp_clk) code <= v[i];
         repeat (10) @(posedge i_smp_clk);
         check({dir_w, del_w}, {2{v[i] ^ 8'h80}}, "offset binary");
      end
      $display("done data");
   endtask

   task automatic t_ext;
      logic [15:0] pat = 16'hA5C3;
      dly <= 1'b1;
      pins(2'h0, 2'h2, 1'b0);
      check(ext, 1'b1, "ext mode");
      check({rng_hi, swing_n}, 2'h1, "ctrl reset settings");
      wb(1'b0, 8'h00, 32'h0);
      check(q, 32'hA, "ctrl reset");
      wb(1'b1, 8'h00, 32'h5);
      repeat (4) @(posedge i_clk);
      check({rng_hi, swing_n}, 2'h2, "ctrl settings");
      wb(1'b0, 8'h04, 32'h0);
      check(q[5], 1'b0, "delay forced short");
      dly <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         edg <= pat[i] ? 2'h2 : 2'h1;
         repeat (4) @(posedge i_clk) swing <= 1'b1;
         repeat (4) @(posedge i_clk) swing <= 1'b0;
      end
      repeat (4) @(posedge i_clk);
      edg <= pat[0] ? 2'h1 : 2'h2;
      wb(1'b0, 8'h08, 32'h0);
      check(q, 32'h0000A5C3, "serial word");
      wb(1'b0, 8'h04, 32'h0);
      check(q[11:6], 6'h10, "serial count");
      dly <= 1'b1;
      pins(2'h2, 2'h2, 1'b1);
      $display("done ext");
   endtask

   task automatic t_cal;
      int n;
      n = 0;
      @(posedge i_smp_clk) cal <= 1'b1;
      repeat (2) @(posedge i_smp_clk);
      cal <= 1'b0;
      repeat (30) @(posedge i_smp_clk) n += cal_f;
      check(n, 0, "short high ignored");
      @(posedge i_smp_clk) cal <= 1'b1;
      repeat (8) @(posedge i_smp_clk);
      cal <= 1'b0;
      repeat (40) @(posedge i_smp_clk) n += cal_f;
      check(n, 16, "cal run length");
      $display("done cal");
   endtask

   task automatic t_sync;
      int r0;
      @(posedge i_smp_clk) srst <= 1'b1;
      repeat (2) @(posedge i_smp_clk);
      srst <= 1'b0;
      repeat (2) @(posedge i_smp_clk);
      check(output_data_clock, 1'b0, "clock held low");
      @(posedge i_smp_clk) check(output_data_clock, 1'b0, "clock low after sync");
      @(posedge i_smp_clk) check(output_data_clock, 1'b1, "clock aligned rise");
      r0 = rises;
      repeat (8) @(posedge i_smp_clk);
      check(rises - r0 >= 3, 1'b1, "clock restarts");
      $display("done sync");
   endtask

   task automatic t_pd;
      @(posedge i_clk) pd <= 1'b1;
      repeat (8) @(posedge i_clk);
      check({pd_o, swing_n}, 2'h2, "power down");
      check({dir_b, del_b}, 16'h0, "buses idle");
      wb(1'b0, 8'h04, 32'h0);
      check({q[5], q[1]}, 2'h3, "status long delay and power down");
      @(posedge i_clk) pd <= 1'b0;
      repeat (8) @(posedge i_clk);
      check(pd_o, 1'b0, "power up");
      $display("done pd");
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (40) @(posedge i_clk);
      t_normal;
      t_edge;
      t_data;
      t_ext;
      t_cal;
      t_sync;
      t_pd;
      finish_test(1'b0);
   end
endmodule
